// *** xgc_pkg.sv ***
package xgc_pkg;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [4:0] XGC_REG_EXT_STATUS = 5'h0f;
  localparam logic [4:0] XGC_REG_GLOBAL_CFG = 5'h10;

  // ---------------------------------------------------------------
  // Global configuration fields
  // ---------------------------------------------------------------
  localparam int XGC_B_DESKEW = 14;
  localparam int XGC_B_LANE_SYNC = 13;
  localparam int XGC_B_IPG = 12;
  localparam int XGC_B_CTC = 11;
  localparam int XGC_B_MF_HI = 10;
  localparam int XGC_B_MF_LO = 9;
  localparam int XGC_B_LOS = 8;
  localparam int XGC_B_CFG_HI = 7;
  localparam int XGC_B_CFG_LO = 6;
  localparam int XGC_B_PRE_HI = 5;
  localparam int XGC_B_PRE_LO = 4;
  localparam int XGC_B_PRBS = 2;
  localparam int XGC_B_COMMA = 1;

  // Plain read/write bits; strap-gated bits are handled one by one
  localparam logic [15:0] XGC_RW_MASK = 16'h7f32;
  localparam logic [15:0] XGC_GCFG_RESET = 16'h0102;
  localparam logic [15:0] XGC_EXT_STATUS_VAL = 16'h0000;
  localparam logic [15:0] XGC_UNMAPPED_VAL = 16'h0000;

  // ---------------------------------------------------------------
  // Multifunction pin selections
  // ---------------------------------------------------------------
  localparam logic [1:0] XGC_MF_IO_STD = 2'h0;
  localparam logic [1:0] XGC_MF_COMMA = 2'h1;
  localparam logic [1:0] XGC_MF_LOS = 2'h2;
  localparam logic [1:0] XGC_MF_PRBS = 2'h3;

  // ---------------------------------------------------------------
  // Management frame
  // ---------------------------------------------------------------
  localparam logic [5:0] XGC_PRE_BITS = 6'h20;
  localparam logic [3:0] XGC_HDR_LAST = 4'hb;
  localparam logic [3:0] XGC_DATA_LAST = 4'hf;
  localparam logic [1:0] XGC_OP_RD = 2'h2;
  localparam logic [1:0] XGC_OP_WR = 2'h1;

  // Pin synchroniser lanes
  localparam int XGC_P_MDC = 0;
  localparam int XGC_P_MDIO = 1;
  localparam int XGC_P_HSTL = 2;
  localparam int XGC_P_CFG_HI = 3;
  localparam int XGC_P_CFG_LO = 4;
  localparam int XGC_P_PRBS = 5;
  localparam int XGC_NPINS = 6;

  typedef enum logic [2:0] {
    XGC_S_PRE,
    XGC_S_ST,
    XGC_S_HDR,
    XGC_S_TA1,
    XGC_S_TA2,
    XGC_S_RDAT,
    XGC_S_WDAT
  } xgc_state_e;

endpackage : xgc_pkg

// *** xgc_mgmt_if.sv ***
`timescale 1ns/1ps
`default_nettype none

interface xgc_mgmt_if;
  logic wr_stb;
  logic [4:0] addr;
  logic [15:0] wdata;
  logic [15:0] rdata;

  modport engine (output wr_stb, output addr, output wdata, input rdata);
  modport bank (input wr_stb, input addr, input wdata, output rdata);
endinterface : xgc_mgmt_if

`default_nettype wire

// *** xgc_cfg_bank.sv ***
`timescale 1ns/1ps
`default_nettype none

module xgc_cfg_bank
  import xgc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic nrst,
  xgc_mgmt_if.bank bus,
  input wire logic strap_cfg_hi,
  input wire logic strap_cfg_lo,
  input wire logic strap_prbs_test,
  output logic [15:0] cfg_eff,
  output logic chan_load,
  output logic [15:0] chan_load_data
);

  typedef struct packed {
    logic [15:0] cfg;
    logic [15:0] eff;
    logic chan_load;
    logic [15:0] chan_data;
  } xgc_bank_s;

  xgc_bank_s r;
  xgc_bank_s nxt;

  // ---------------------------------------------------------------
  // Write and force logic
  // ---------------------------------------------------------------
  always_comb begin
    nxt = r;
    nxt.chan_load = 1'b0;
    if (bus.wr_stb && bus.addr == XGC_REG_GLOBAL_CFG) begin
      // Reserved bits never enter the store
      nxt.cfg = (r.cfg & ~XGC_RW_MASK) | (bus.wdata & XGC_RW_MASK);
      // Forced bits keep their stored value for when the force drops
      if (!strap_cfg_hi) begin
        nxt.cfg[XGC_B_CFG_HI] = bus.wdata[XGC_B_CFG_HI];
      end
      if (!strap_cfg_lo) begin
        nxt.cfg[XGC_B_CFG_LO] = bus.wdata[XGC_B_CFG_LO];
      end
      if (!strap_prbs_test) begin
        nxt.cfg[XGC_B_PRBS] = bus.wdata[XGC_B_PRBS];
      end
      nxt.chan_load = 1'b1;
      nxt.chan_data = nxt.cfg;
    end
    nxt.eff = nxt.cfg;
    nxt.eff[XGC_B_CFG_HI] = nxt.cfg[XGC_B_CFG_HI] | strap_cfg_hi;
    nxt.eff[XGC_B_CFG_LO] = nxt.cfg[XGC_B_CFG_LO] | strap_cfg_lo;
    nxt.eff[XGC_B_PRBS] = nxt.cfg[XGC_B_PRBS] | strap_prbs_test;
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      r.cfg <= XGC_GCFG_RESET;
      r.eff <= XGC_GCFG_RESET;
      r.chan_load <= 1'b0;
      r.chan_data <= XGC_GCFG_RESET;
    end else begin
      r <= nxt;
    end
  end

  // ---------------------------------------------------------------
  // Read decode
  // ---------------------------------------------------------------
  always_comb begin
    unique case (bus.addr)
      XGC_REG_EXT_STATUS: bus.rdata = XGC_EXT_STATUS_VAL;
      XGC_REG_GLOBAL_CFG: bus.rdata = r.eff;
      default: bus.rdata = XGC_UNMAPPED_VAL;
    endcase
  end

  assign cfg_eff = r.eff;
  assign chan_load = r.chan_load;
  assign chan_load_data = r.chan_data;

endmodule : xgc_cfg_bank

`default_nettype wire

// *** xgc_global_regs.sv ***
`timescale 1ns/1ps
`default_nettype none

// How it works
// - The extended status register always reads zero and ignores writes.
// - A global configuration write also reloads all four lane registers.
// - Bit 15 of the global register reads zero and cannot be written.
// - Bit 14 enables lane deskew and resets to zero.
// - Bit 13 enables lane synchronisation and resets to zero.
// - Bit 12 enables inter-packet-gap management and resets to zero.
// - Bit 11 enables clock tolerance compensation and resets to zero.
// - Bits 10:9 pick I/O standard, comma, loss of signal or PRBS pass.
// - Bit 8 enables loss-of-signal detection and resets to one.
// - Bit 7 is ORed with the high strap and writable only while it is low.
// - Bit 6 is ORed with the low strap and writable only while it is low.
// - Bits 5 and 4 are read/write preemphasis controls resetting to zero.
// - Bits 3 and 0 read zero and ignore writes.
// - Bit 2 enables PRBS, ORed with its strap, writable only while low.
// - Bit 1 enables comma detection and alignment and resets to one.
// - Writes to a forced bit are dropped and its old value returns later.

module xgc_global_regs
  import xgc_pkg::*;
#(
  parameter logic [4:0] PHY_ADDR = 5'h00
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic mdc,
  input wire logic mdio_i,
  output logic mdio_o,
  output logic mdio_oe,
  input wire logic io_std_hstl,
  input wire logic strap_cfg_hi,
  input wire logic strap_cfg_lo,
  input wire logic strap_prbs_test,
  input wire logic [3:0] lane_comma_det,
  input wire logic [3:0] lane_los,
  input wire logic [3:0] lane_prbs_pass,
  output logic deskew_en,
  output logic lane_sync_en,
  output logic inter_packet_gap_en,
  output logic ctc_en,
  output logic los_det_en,
  output logic cfg_hi,
  output logic cfg_lo,
  output logic preemph_hi,
  output logic preemph_lo,
  output logic prbs_en,
  output logic comma_det_en,
  output logic [3:0] multifunction_pins,
  output logic chan_load,
  output logic [15:0] chan_load_data
);

  typedef struct packed {
    logic [XGC_NPINS-1:0] s1;
    logic [XGC_NPINS-1:0] s2;
    logic mdc_d;
    xgc_state_e st;
    logic [5:0] pre_cnt;
    logic [3:0] cnt;
    logic [1:0] op;
    logic [4:0] reg_a;
    logic hit;
    logic [15:0] sh;
    logic wr;
    logic [15:0] wdata;
    logic mdio_o;
    logic mdio_oe;
    logic [3:0] mf;
  } xgc_top_s;

  xgc_top_s r;
  xgc_top_s nxt;
  logic [XGC_NPINS-1:0] pins;
  logic rise;
  logic bit_in;
  logic [11:0] hdr;
  logic [15:0] cfg_eff;

  xgc_mgmt_if mbus ();

  assign pins = {strap_prbs_test, strap_cfg_lo, strap_cfg_hi,
                 io_std_hstl, mdio_i, mdc};

  // Edge and data come through equal synchroniser depth, so they align
  assign rise = r.s2[XGC_P_MDC] && !r.mdc_d;
  assign bit_in = r.s2[XGC_P_MDIO];
  assign hdr = {r.sh[10:0], bit_in};

  // ---------------------------------------------------------------
  // Frame engine
  // ---------------------------------------------------------------
  always_comb begin
    nxt = r;
    nxt.s1 = pins;
    nxt.s2 = r.s1;
    nxt.mdc_d = r.s2[XGC_P_MDC];
    nxt.wr = 1'b0;
    if (rise) begin
      unique case (r.st)
        XGC_S_PRE: begin
          if (bit_in) begin
            if (r.pre_cnt != XGC_PRE_BITS) begin
              nxt.pre_cnt = r.pre_cnt + 6'h01;
            end
          end else if (r.pre_cnt == XGC_PRE_BITS) begin
            nxt.st = XGC_S_ST;
          end else begin
            nxt.pre_cnt = 6'h00;
          end
        end
        XGC_S_ST: begin
          nxt.pre_cnt = 6'h00;
          nxt.cnt = 4'h0;
          nxt.st = bit_in ? XGC_S_HDR : XGC_S_PRE;
        end
        XGC_S_HDR: begin
          nxt.sh = {r.sh[14:0], bit_in};
          nxt.cnt = r.cnt + 4'h1;
          if (r.cnt == XGC_HDR_LAST) begin
            nxt.op = hdr[11:10];
            nxt.reg_a = hdr[4:0];
            nxt.hit = (hdr[9:5] == PHY_ADDR);
            // Unknown opcodes drop the frame and wait for a preamble
            if (hdr[11:10] == XGC_OP_RD || hdr[11:10] == XGC_OP_WR) begin
              nxt.st = XGC_S_TA1;
            end else begin
              nxt.st = XGC_S_PRE;
            end
          end
        end
        XGC_S_TA1: begin
          nxt.st = XGC_S_TA2;
          if (r.op == XGC_OP_RD) begin
            nxt.sh = mbus.rdata;
            nxt.mdio_o = 1'b0;
            nxt.mdio_oe = r.hit;
          end
        end
        XGC_S_TA2: begin
          nxt.cnt = 4'h0;
          if (r.op == XGC_OP_RD) begin
            nxt.mdio_o = r.sh[15];
            nxt.sh = {r.sh[14:0], 1'b0};
            nxt.st = XGC_S_RDAT;
          end else begin
            nxt.st = XGC_S_WDAT;
          end
        end
        XGC_S_RDAT: begin
          nxt.cnt = r.cnt + 4'h1;
          if (r.cnt == XGC_DATA_LAST) begin
            nxt.mdio_o = 1'b0;
            nxt.mdio_oe = 1'b0;
            nxt.st = XGC_S_PRE;
          end else begin
            nxt.mdio_o = r.sh[15];
            nxt.sh = {r.sh[14:0], 1'b0};
          end
        end
        XGC_S_WDAT: begin
          nxt.cnt = r.cnt + 4'h1;
          nxt.sh = {r.sh[14:0], bit_in};
          if (r.cnt == XGC_DATA_LAST) begin
            // Status register has no store, so a write there is inert
            nxt.wr = r.hit;
            nxt.wdata = {r.sh[14:0], bit_in};
            nxt.st = XGC_S_PRE;
          end
        end
        default: nxt.st = XGC_S_PRE;
      endcase
    end

    // Multifunction pins, one per lane, all four updated every cycle
    for (int i = 0; i < 4; i++) begin
      unique case (cfg_eff[XGC_B_MF_HI:XGC_B_MF_LO])
        XGC_MF_IO_STD: nxt.mf[i] = r.s2[XGC_P_HSTL];
        XGC_MF_COMMA: nxt.mf[i] = lane_comma_det[i];
        XGC_MF_LOS: nxt.mf[i] = lane_los[i];
        XGC_MF_PRBS: nxt.mf[i] = lane_prbs_pass[i];
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      r.s1 <= '0;
      r.s2 <= '0;
      r.mdc_d <= 1'b0;
      r.st <= XGC_S_PRE;
      r.pre_cnt <= 6'h00;
      r.cnt <= 4'h0;
      r.op <= 2'h0;
      r.reg_a <= 5'h00;
      r.hit <= 1'b0;
      r.sh <= 16'h0000;
      r.wr <= 1'b0;
      r.wdata <= 16'h0000;
      r.mdio_o <= 1'b0;
      r.mdio_oe <= 1'b0;
      r.mf <= 4'h0;
    end else begin
      r <= nxt;
    end
  end

  assign mbus.wr_stb = r.wr;
  assign mbus.addr = r.reg_a;
  assign mbus.wdata = r.wdata;

  // ---------------------------------------------------------------
  // Register bank
  // ---------------------------------------------------------------
  xgc_cfg_bank u_bank (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .bus(mbus.bank),
    .strap_cfg_hi(r.s2[XGC_P_CFG_HI]),
    .strap_cfg_lo(r.s2[XGC_P_CFG_LO]),
    .strap_prbs_test(r.s2[XGC_P_PRBS]),
    .cfg_eff(cfg_eff),
    .chan_load(chan_load),
    .chan_load_data(chan_load_data)
  );

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign deskew_en = cfg_eff[XGC_B_DESKEW];
  assign lane_sync_en = cfg_eff[XGC_B_LANE_SYNC];
  assign inter_packet_gap_en = cfg_eff[XGC_B_IPG];
  assign ctc_en = cfg_eff[XGC_B_CTC];
  assign los_det_en = cfg_eff[XGC_B_LOS];
  assign cfg_hi = cfg_eff[XGC_B_CFG_HI];
  assign cfg_lo = cfg_eff[XGC_B_CFG_LO];
  assign preemph_hi = cfg_eff[XGC_B_PRE_HI];
  assign preemph_lo = cfg_eff[XGC_B_PRE_LO];
  assign prbs_en = cfg_eff[XGC_B_PRBS];
  assign comma_det_en = cfg_eff[XGC_B_COMMA];
  assign multifunction_pins = r.mf;
  assign mdio_o = r.mdio_o;
  assign mdio_oe = r.mdio_oe;

endmodule : xgc_global_regs

`default_nettype wire

// *** xgc_global_regs_monitor.sv ***
`timescale 1ns/1ps
`default_nettype none

module xgc_global_regs_monitor (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic strap_cfg_hi,
  input wire logic strap_cfg_lo,
  input wire logic strap_prbs_test,
  input wire logic deskew_en,
  input wire logic lane_sync_en,
  input wire logic inter_packet_gap_en,
  input wire logic ctc_en,
  input wire logic los_det_en,
  input wire logic cfg_hi,
  input wire logic cfg_lo,
  input wire logic preemph_hi,
  input wire logic prbs_en,
  input wire logic comma_det_en,
  input wire logic chan_load,
  input wire logic [15:0] chan_load_data
);
  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  chk_reset_off: assert property (
    $rose(nrst) |-> !deskew_en && !lane_sync_en &&
    !inter_packet_gap_en && !ctc_en)
    else $error("enable set after reset");
  chk_reset_on: assert property (
    $rose(nrst) |-> los_det_en && comma_det_en && !preemph_hi)
    else $error("reset value wrong");
  chk_load_pulse: assert property (chan_load |=> !chan_load)
    else $error("lane reload longer than one cycle");
  chk_load_reserved: assert property (
    chan_load |-> !chan_load_data[15] && !chan_load_data[3] &&
    !chan_load_data[0]) else $error("reserved bit stored");
  chk_load_apply: assert property (chan_load |->
    deskew_en == chan_load_data[14] && ctc_en == chan_load_data[11] &&
    los_det_en == chan_load_data[8] && comma_det_en == chan_load_data[1])
    else $error("enables differ from stored value");
  chk_strap_hi: assert property (strap_cfg_hi [*5] |-> cfg_hi)
    else $error("high strap not ORed in");
  chk_strap_lo: assert property (strap_cfg_lo [*5] |-> cfg_lo)
    else $error("low strap not ORed in");
  chk_strap_prbs: assert property (strap_prbs_test [*5] |-> prbs_en)
    else $error("prbs strap not ORed in");
  // Strap held long enough to be past the synchroniser
  chk_forced_keep: assert property (
    strap_cfg_hi [*6] ##0 chan_load |->
    chan_load_data[7] == $past(chan_load_data[7]))
    else $error("forced bit written");

  cover property (chan_load);
  cover property (chan_load && strap_cfg_hi);
  cover property ($rose(nrst));
endmodule : xgc_global_regs_monitor

bind xgc_global_regs xgc_global_regs_monitor u_mon (
  .clk_sys(clk_sys), .nrst(nrst), .strap_cfg_hi(strap_cfg_hi),
  .strap_cfg_lo(strap_cfg_lo), .strap_prbs_test(strap_prbs_test),
  .deskew_en(deskew_en), .lane_sync_en(lane_sync_en),
  .inter_packet_gap_en(inter_packet_gap_en), .ctc_en(ctc_en),
  .los_det_en(los_det_en), .cfg_hi(cfg_hi), .cfg_lo(cfg_lo),
  .preemph_hi(preemph_hi), .prbs_en(prbs_en), .comma_det_en(comma_det_en),
  .chan_load(chan_load), .chan_load_data(chan_load_data)
);

`default_nettype wire

// *** xgc_mdio_station.sv ***
`timescale 1ns/1ps
`default_nettype none

module xgc_mdio_station
  import xgc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic mdio_o,
  input wire logic mdio_oe,
  output logic mdc,
  output logic mdio_i
);
  // ----------------------------------------
  // Management station
  // ----------------------------------------
  logic drv = 1'b1;
  logic drv_en = 1'b1;

  // Pull-up on the shared line: nobody driving reads high
  assign mdio_i = mdio_oe ? mdio_o : (drv_en ? drv : 1'b1);
  initial mdc = 1'b0;

  // Clock parks low between frames; 8 cycles per half period
  task automatic xfer(input logic [1:0] op, input logic [4:0] phy,
                      input logic [4:0] ra, input logic [15:0] wd,
                      output logic [15:0] rd);
    logic [63:0] fr;
    fr = {32'hffffffff, 2'b01, op, phy, ra, 2'b10, wd};
    rd = 16'h0000;
    for (int i = 63; i >= 0; i--) begin
      @(posedge clk_sys);
      mdc <= 1'b0;
      drv <= fr[i];
      drv_en <= !(op == XGC_OP_RD && i < 18);
      repeat (8) @(posedge clk_sys);
      mdc <= 1'b1;
      if (i < 16) rd = {rd[14:0], mdio_i};
      repeat (7) @(posedge clk_sys);
    end
    @(posedge clk_sys);
    mdc <= 1'b0;
    drv_en <= 1'b0;
  endtask : xfer
endmodule : xgc_mdio_station

`default_nettype wire

// *** xgc_global_regs_tb.sv ***
`timescale 1ns/1ps
`default_nettype none

module xgc_global_regs_tb
  import xgc_pkg::*;
;
  // ----------------------------------------
  // Bench
  // ----------------------------------------
  localparam logic [4:0] PHY = 5'h05;
  localparam logic [4:0] G = XGC_REG_GLOBAL_CFG;
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic io_std_hstl = 1'b1;
  logic strap_cfg_hi = 1'b0, strap_cfg_lo = 1'b0, strap_prbs_test = 1'b0;
  logic [3:0] lane_comma_det = 4'h5, lane_los = 4'ha, lane_prbs_pass = 4'h3;
  logic mdc, mdio_i, mdio_o, mdio_oe, chan_load;
  logic deskew_en, lane_sync_en, inter_packet_gap_en, ctc_en, los_det_en;
  logic cfg_hi, cfg_lo, preemph_hi, preemph_lo, prbs_en, comma_det_en;
  logic [3:0] multifunction_pins;
  logic [3:0] mf_exp [4] = '{4'hf, 4'h5, 4'ha, 4'h3};
  logic [15:0] chan_load_data, last_load = 16'h0000, n_load = 16'h0000, n0;
  logic [10:0] en_v;
  logic [15:0] echo;
  int n_errors = 0, total_checks = 0;

  assign en_v = {deskew_en, lane_sync_en, inter_packet_gap_en, ctc_en,
    los_det_en, cfg_hi, cfg_lo, preemph_hi, preemph_lo, prbs_en, comma_det_en};

  xgc_global_regs #(.PHY_ADDR(PHY)) dut (
    .clk_sys(clk_sys), .nrst(nrst), .mdc(mdc), .mdio_i(mdio_i),
    .mdio_o(mdio_o), .mdio_oe(mdio_oe), .io_std_hstl(io_std_hstl),
    .strap_cfg_hi(strap_cfg_hi), .strap_cfg_lo(strap_cfg_lo),
    .strap_prbs_test(strap_prbs_test), .lane_comma_det(lane_comma_det),
    .lane_los(lane_los), .lane_prbs_pass(lane_prbs_pass),
    .deskew_en(deskew_en), .lane_sync_en(lane_sync_en),
    .inter_packet_gap_en(inter_packet_gap_en), .ctc_en(ctc_en),
    .los_det_en(los_det_en), .cfg_hi(cfg_hi), .cfg_lo(cfg_lo),
    .preemph_hi(preemph_hi), .preemph_lo(preemph_lo), .prbs_en(prbs_en),
    .comma_det_en(comma_det_en), .multifunction_pins(multifunction_pins),
    .chan_load(chan_load), .chan_load_data(chan_load_data)
  );

  xgc_mdio_station st (
    .clk_sys(clk_sys), .mdio_o(mdio_o), .mdio_oe(mdio_oe), .mdc(mdc),
    .mdio_i(mdio_i)
  );

  initial forever #2.5 clk_sys = ~clk_sys;

  always @(posedge clk_sys) if (chan_load === 1'b1) begin
    n_load <= n_load + 16'h0001;
    last_load <= chan_load_data;
  end

  task automatic chk(input string nm, input logic [15:0] got, exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value %s exp %h got %h", nm, exp, got);
    end
  endtask : chk

  task automatic rd(input logic [4:0] ra, input logic [15:0] exp);
    logic [15:0] got;
    st.xfer(XGC_OP_RD, PHY, ra, 16'h0000, got);
    chk("readback", got, exp);
  endtask : rd

  task automatic wr(input logic [4:0] ra, input logic [15:0] wd);
    logic [15:0] got;
    st.xfer(XGC_OP_WR, PHY, ra, wd, got);
  endtask : wr

  task automatic straps(input logic [2:0] v);
    @(posedge clk_sys);
    {strap_cfg_hi, strap_cfg_lo, strap_prbs_test} <= v;
  endtask : straps

  task automatic complete_run();
    if (n_errors == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : complete_run

  // Frames take about a thousand cycles each
  initial begin
    repeat (60000) @(posedge clk_sys);
    n_errors++;
    complete_run();
  end

  initial begin
    repeat (5) @(posedge clk_sys);
    nrst <= 1'b1;
    rd(G, XGC_GCFG_RESET);
    rd(XGC_REG_EXT_STATUS, 16'h0000);
    wr(XGC_REG_EXT_STATUS, 16'hffff);
    chk("loads", n_load, 16'h0000);
    rd(XGC_REG_EXT_STATUS, 16'h0000);
    wr(G, 16'hffff);
    chk("loads", n_load, 16'h0001);
    chk("stored", last_load, 16'h7ff6);
    rd(G, 16'h7ff6);
    chk("enables", {5'h00, en_v}, 16'h07ff);
    for (int s = 0; s < 4; s++) begin
      wr(G, {5'h00, s[1:0], 9'h102});
      chk("mf pins", 16'(multifunction_pins), 16'(mf_exp[s]));
    end
    // Select 00 with the I/O standard pin low shows SSTL as zeros
    io_std_hstl <= 1'b0;
    wr(G, 16'h0102);
    chk("mf pins", 16'(multifunction_pins), 16'h0000);
    wr(G, 16'h00c4);
    straps(3'h7);
    wr(G, 16'h0000);
    chk("stored", last_load, 16'h00c4);
    rd(G, 16'h00c4);
    straps(3'h0);
    rd(G, 16'h00c4);
    wr(G, 16'h0000);
    straps(3'h7);
    repeat (6) @(posedge clk_sys);
    chk("enables", {5'h00, en_v}, 16'h0032);
    rd(G, 16'h00c4);
    straps(3'h0);
    rd(G, 16'h0000);
    // Frame for another address must leave the bank untouched
    n0 = n_load;
    st.xfer(XGC_OP_WR, PHY + 5'h01, G, 16'h4000, echo);
    chk("loads", n_load, n0);
    rd(G, 16'h0000);
    nrst <= 1'b0;
    repeat (5) @(posedge clk_sys);
    nrst <= 1'b1;
    rd(G, XGC_GCFG_RESET);
    complete_run();
  end
endmodule : xgc_global_regs_tb

`default_nettype wire
